// File: shared/ipdc_consts.vh
/*
 * constants of the idle / power-down controller: power control bit
 * positions, reset values, vectors and reset timing counts.
 * assumes one oscillator-derived clock of 200 MHz.
 */
`ifndef IPDC_CONSTS_VH
`define IPDC_CONSTS_VH

// ============================================================
// power control register fields
`define IPDC_POWER_CONTROL_REG_IDLE_BIT      0
`define IPDC_POWER_CONTROL_REG_PD_BIT        1
`define IPDC_POWER_CONTROL_REG_WIDTH         8
`define IPDC_POWER_CONTROL_REG_RESET         8'h00

// ============================================================
// vectors and reset values
`define IPDC_RESET_VECTOR       16'h0000
`define IPDC_WAKE_VECTOR        16'h0023
`define IPDC_PORT_RESET         8'hFF
`define IPDC_PORT_WIDTH         8

// ============================================================
// reset pin qualification: 24 oscillator periods (two machine cycles)
`define IPDC_RESET_OSC_PERIODS  24
`define IPDC_CLK_PERIOD_PS      5000
`define IPDC_OSC_PERIOD_PS      5000
`define IPDC_RESET_CYCLES       ((`IPDC_RESET_OSC_PERIODS * `IPDC_OSC_PERIOD_PS + `IPDC_CLK_PERIOD_PS - 1) / `IPDC_CLK_PERIOD_PS)
`define IPDC_CNT_WIDTH          5

`endif

// File: rtl/ipdc_idle_powerdown_controller.v
/*
 * idle and power-down controller: gates the core clock in idle, freezes
 * the oscillator in power-down, wakes idle on enabled interrupt or reset pin, power-down on reset pin only.
 * assumes the core pulses i_power_control_reg_we at completion of the writing
 * instruction and honours o_core_clk_en; all inputs except the asynchronous i_arst_n synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_consts.vh"

module ipdc_idle_powerdown_controller (
  input  wire        i_clock,
  input  wire        i_arst_n,
  input  wire        i_reset_pin,
  input  wire        i_power_control_reg_we,
  input  wire [7:0]  i_power_control_reg_wdata,
  input  wire        i_irq_pending,
  input  wire        i_irq_enabled,
  output wire        o_osc_run,
  output wire        o_core_clk_en,
  output wire        o_periph_clk_en,
  output wire        o_ram_clk_en,
  output reg  [7:0]  o_power_control_reg,
  output reg         o_sfr_reset,
  output reg         o_ram_hold,
  output reg  [7:0]  o_port_latch_init,
  output reg         o_port_init,
  output reg         o_wake_irq,
  output reg         o_wake_vector_en,
  output reg  [15:0] o_wake_vector,
  output wire [2:0]  o_state
);

  // ============================================================
  // states
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_PD   = 3'b100;

  reg  [2:0]                   state_reg;
  reg  [2:0]                   state_next;
  reg  [`IPDC_CNT_WIDTH-1:0]   rst_cnt_reg;
  reg                          rst_done_reg;
  reg                          ie_latched_reg;
  wire                         rst_qual;
  wire                         wake_irq;

  // ============================================================
  // shared decode
  // write that asks for one low-power bit
  function power_control_reg_req;
    input       we;
    input [7:0] data;
    input integer pos;
    begin
      power_control_reg_req = we && data[pos];
    end
  endfunction

  // clocks that survive idle but stop in power-down
  function clk_alive;
    input [2:0] state;
    begin
      clk_alive = (state != ST_PD);
    end
  endfunction

  // reset pin just released with interrupts enabled
  function reset_wake;
    input done;
    input pin;
    input ie;
    begin
      reset_wake = done && !pin && ie;
    end
  endfunction

  assign rst_qual = i_reset_pin && (rst_cnt_reg == (`IPDC_RESET_CYCLES - 1));
  assign wake_irq = (state_reg == ST_IDLE) && i_irq_pending && i_irq_enabled;

  // ============================================================
  // reset pin qualification
  // two machine cycles
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_cnt_reg  <= {`IPDC_CNT_WIDTH{1'b0}};
      rst_done_reg <= 1'b0;
    end else if (!i_reset_pin) begin
      rst_cnt_reg  <= {`IPDC_CNT_WIDTH{1'b0}};
      rst_done_reg <= 1'b0;
    end else if (rst_cnt_reg != (`IPDC_RESET_CYCLES - 1)) begin
      rst_cnt_reg  <= rst_cnt_reg + 1'b1;
    end else begin
      rst_done_reg <= 1'b1;
    end
  end

  // ============================================================
  // mode sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (power_control_reg_req(i_power_control_reg_we, i_power_control_reg_wdata, `IPDC_POWER_CONTROL_REG_PD_BIT))
          state_next = ST_PD;
        else if (power_control_reg_req(i_power_control_reg_we, i_power_control_reg_wdata, `IPDC_POWER_CONTROL_REG_IDLE_BIT))
          state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (wake_irq)
          state_next = ST_RUN;
      end
      ST_PD: begin
        state_next = ST_PD;
      end
      default: state_next = ST_RUN;
    endcase
    // reset is the only way out of power-down
    if (rst_qual)
      state_next = ST_RUN;
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // power control register
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_control_reg <= `IPDC_POWER_CONTROL_REG_RESET;
      ie_latched_reg      <= 1'b0;
    end else begin
      if (rst_qual) begin
        o_power_control_reg <= `IPDC_POWER_CONTROL_REG_RESET;
        ie_latched_reg      <= i_irq_enabled;
      end else if (state_reg == ST_RUN && i_power_control_reg_we) begin
        o_power_control_reg <= i_power_control_reg_wdata;
      end else if (wake_irq) begin
        o_power_control_reg[`IPDC_POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;
      end
    end
  end

  // ============================================================
  // clock gates
  // core clock gated in idle
  assign o_core_clk_en   = (state_reg == ST_RUN);
  assign o_periph_clk_en = clk_alive(state_reg);
  assign o_ram_clk_en    = clk_alive(state_reg);
  assign o_osc_run       = clk_alive(state_reg);
  assign o_state         = state_reg;

  // ============================================================
  // reset outputs
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_reset       <= 1'b1;
      o_ram_hold        <= 1'b1;
      o_port_latch_init <= `IPDC_PORT_RESET;
      o_port_init       <= 1'b1;
    end else begin
      // RAM and registers held in power-down
      o_ram_hold        <= (state_next == ST_PD) || i_reset_pin;
      o_sfr_reset       <= rst_qual || rst_done_reg;
      o_port_init       <= i_reset_pin;
      o_port_latch_init <= `IPDC_PORT_RESET;
    end
  end

  // ============================================================
  // wake outputs
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake_irq        <= 1'b0;
      o_wake_vector_en  <= 1'b0;
      o_wake_vector     <= `IPDC_RESET_VECTOR;
    end else begin
      o_wake_irq        <= wake_irq;
      o_wake_vector_en  <= reset_wake(rst_done_reg, i_reset_pin, ie_latched_reg);
      o_wake_vector     <= reset_wake(rst_done_reg, i_reset_pin, ie_latched_reg) ?
                           `IPDC_WAKE_VECTOR : `IPDC_RESET_VECTOR;
    end
  end

endmodule
`default_nettype wire

// File: verif/ipdc_idle_powerdown_controller_props.sv
/* checker of the idle / power-down controller.
   assumes the top module ports; attached by bind. */
`timescale 1ns/1ps
`default_nettype none
module ipdc_props (
  input wire logic       i_clock,
  input wire logic       i_arst_n,
  input wire logic       i_reset_pin,
  input wire logic       i_power_control_reg_we,
  input wire logic [7:0] i_power_control_reg_wdata,
  input wire logic       i_irq_pending,
  input wire logic       i_irq_enabled,
  input wire logic       o_osc_run,
  input wire logic       o_core_clk_en,
  input wire logic       o_periph_clk_en,
  input wire logic [7:0] o_power_control_reg,
  input wire logic       o_wake_irq,
  input wire logic       o_port_init,
  input wire logic [7:0] o_port_latch_init,
  input wire logic [2:0] o_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // ============================================================
  // consecutive cycles with reset pin high
  reg [4:0] cnt_reg;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) cnt_reg <= 5'h00;
    else cnt_reg <= !i_reset_pin ? 5'h00 : (cnt_reg == 5'h1F ? cnt_reg : cnt_reg + 5'h01);
  end
  wire run = o_state == 3'b001;
  idle_entry_a: assert property (run && i_power_control_reg_we && i_power_control_reg_wdata[1:0] == 2'h1 && !i_reset_pin |=>
    o_state == 3'b010 && !o_core_clk_en) else $error("idle entry wrong");
  pd_entry_a: assert property (run && i_power_control_reg_we && i_power_control_reg_wdata[1] && !i_reset_pin |=>
    o_state == 3'b100 && !o_osc_run) else $error("power-down entry wrong");
  idle_clocks_a: assert property (o_state == 3'b010 |-> o_osc_run && o_periph_clk_en) else $error("idle clocks");
  irq_wake_a: assert property (o_state == 3'b010 && i_irq_pending && i_irq_enabled && !i_reset_pin |=>
    run && o_wake_irq && !o_power_control_reg[0]) else $error("irq wake wrong");
  pd_stays_a: assert property (o_state == 3'b100 && !i_reset_pin |=> o_state == 3'b100) else $error("pd left");
  reset_qual_a: assert property (i_reset_pin && cnt_reg == 5'h17 |=>
    run && o_power_control_reg == 8'h00) else $error("reset qualify wrong");
  hold_regs_a: assert property (!run && !i_reset_pin && !i_irq_pending |=> $stable(o_power_control_reg))
    else $error("registers changed");
  port_init_a: assert property (i_reset_pin |=> o_port_init && o_port_latch_init == 8'hFF)
    else $error("port init wrong");
endmodule
bind ipdc_idle_powerdown_controller ipdc_props i_props (.*);
`default_nettype wire

// File: verif/ipdc_irq_model.sv
/* interrupt source and core service model.
   assumes the controller state and wake pulse. */
`timescale 1ns/1ps
`default_nettype none
module ipdc_irq_model (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic [2:0] i_state,
  input  wire logic       i_ack,
  input  wire logic [3:0] i_delay,
  output logic            o_pending
);
  logic [3:0] cnt_reg;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg   <= 4'h0;
      o_pending <= 1'b0;
    end else if (i_ack || i_state == 3'b001) begin
      cnt_reg   <= 4'h0;
      o_pending <= 1'b0;
    end else if (cnt_reg == i_delay) o_pending <= 1'b1;
    else cnt_reg <= cnt_reg + 4'h1;
  end
endmodule
`default_nettype wire

// File: verif/ipdc_idle_powerdown_controller_tb_top.sv
/* testbench of the idle / power-down controller.
   assumes the checker is bound and the irq model. */
`timescale 1ns/1ps
`default_nettype none
module ipdc_idle_powerdown_controller_tb_top;
  logic clk = 0, rst_n = 0, pin = 0, we = 0, en = 0;
  logic [7:0] wd = 8'h00, d;
  logic [3:0] dly = 4'h3;
  wire pend, wirq, core, sfr, hold, wven;
  wire [15:0] wvec;
  wire [7:0] power_control_reg, port;
  wire [2:0] st;
  int n_mismatch = 0, n_tests = 0, k, s;
  always #2.5 clk = ~clk;
  ipdc_irq_model i_irq (.i_clock(clk), .i_arst_n(rst_n), .i_state(st), .i_ack(wirq), .i_delay(dly), .o_pending(pend));
  ipdc_idle_powerdown_controller i_dut (.i_clock(clk), .i_arst_n(rst_n), .i_reset_pin(pin), .i_power_control_reg_we(we),
    .i_power_control_reg_wdata(wd), .i_irq_pending(pend), .i_irq_enabled(en), .o_osc_run(), .o_core_clk_en(core),
    .o_periph_clk_en(), .o_ram_clk_en(), .o_power_control_reg(power_control_reg), .o_sfr_reset(sfr), .o_ram_hold(hold),
    .o_port_latch_init(port), .o_port_init(), .o_wake_irq(wirq), .o_wake_vector_en(wven), .o_wake_vector(wvec),
    .o_state(st));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] v);
    @(posedge clk) #1 we = 1; wd = v;
    @(posedge clk) #1 we = 0;
  endtask
  task rpin(input int n);
    @(posedge clk) #1 pin = 1;
    repeat (n) @(posedge clk);
    #1 pin = 0;
  endtask
  function logic [2:0] exp_st(input logic [7:0] v);
    return v[1] ? 3'b100 : (v[0] ? 3'b010 : 3'b001);
  endfunction
  task results;
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    results;
  end
  initial begin
    s = $urandom(32'hCD8D81B6);
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    chk(port, 8'hFF);
    for (int i = 0; i < 24; i++) begin
      d = i == 0 ? 8'h03 : (i == 1 ? 8'h01 : $urandom);
      en = i == 1 ? 1'b1 : $urandom;
      dly = $urandom;
      wr(d);
      chk(st, exp_st(d));
      chk(core, d[1:0] == 2'h0);
      if (d[1]) begin
        repeat (20) @(posedge clk);
        chk(hold, 1'b1);
        rpin(10);
        chk(st, 3'b100);
      end else if (d[0] && en) begin
        for (k = 0; k < 20 && wirq !== 1'b1; k++) @(posedge clk) #1;
        chk(wirq, 1'b1);
        chk(power_control_reg[0], 1'b0);
      end
      if (st !== 3'b001) begin
        rpin(24);
        chk(st, 3'b001);
        chk(power_control_reg, 8'h00);
        chk(sfr, 1'b1);
        chk(hold, 1'b1);
        @(posedge clk) #1;
        chk(wven, en);
        chk(wvec, en ? 16'h0023 : 16'h0000);
      end
    end
    results;
  end
endmodule
`default_nettype wire
